// ### core/sacs_top.sv
// What this block does
// RULE1 - Any reset clears registers, turns converter off, aborts conversion.
// RULE2 - Clock field picks bit period: core/2, core/8, core/32, or RC oscillator.
// RULE3 - Channel field codes 000..100 route inputs zero to four to sample-and-hold.
// RULE4 - With converter on, writing status bit one starts conversion; reads one while busy.
// RULE5 - At completion load result, clear status bit, set completion flag together.
// RULE6 - Converter-on bit enables module; cleared means fully off, no current.
// RULE7 - Control bit 1 and configuration bits 7..3 read as zero.
// RULE8 - Codes 000/010 all analog with supply; 001/011 four analog, pin three reference.
// RULE9 - Code 100 channels 0,1,3 analog; 101 channels 0,1 plus reference; 11x digital.
// RULE10 - Result register has no reset; undefined until first conversion completes.
// RULE11 - A conversion lasts nine and a half bit periods.
// RULE12 - Software picks a clock giving bit period of at least 1.6 us.
// RULE13 - Software waits two bit periods after completion before next acquisition.
// RULE14 - Software never turns converter on and starts conversion in one write.
// RULE15 - RC clock keeps running in sleep so conversion continues there.
// RULE16 - Software lets acquisition time pass after channel change before starting.
// RULE17 - Holding capacitor is disconnected from the pin during conversion.
// RULE18 - Port data reads zero on every pin configured analog.
// RULE19 - Software clears flag, sets enables, then clears flag after reading result.
// RULE20 - Result is built by successive approximation on the held sample.
// RULE21 - Start request while converter is off does nothing; bit reads zero.
// RULE22 - Sequencer counts half periods, one bit per period, MSB first, done at nineteen.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sacs_consts.svh"

module sacs_top
	import sacs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire sacs_bus_req_t bus_req,
	output logic [7:0] bus_rdata,
	input wire logic sleep,
	input wire logic rc_half_tick,
	input wire logic cmp_above,
	input wire logic [5:0] port_pin_level,
	output logic module_enable,
	output logic rc_osc_enable,
	output logic sample_connect,
	output logic [2:0] mux_channel,
	output logic [7:0] dac_code,
	output logic ext_ref_select,
	output logic [4:0] analog_channel_mask,
	output logic [7:0] conversion_result,
	output logic conversion_complete_flag,
	output logic conversion_complete_irq_enable
);

	sacs_state_reg_t s_ff;
	sacs_state_reg_t nxt_s;
	logic [7:0] result_ff;
	logic [7:0] nxt_result;
	logic [4:0] ana_ch;
	logic [5:0] pin_analog;
	logic [5:0] port_rd;
	logic ext_ref;
	logic half_tick;
	logic done;

	// ==========================================
	// Pin function decode.
	always_comb begin
		ana_ch = 5'h00;
		ext_ref = 1'b0;
		// RULE8 analog pin map
		unique case (s_ff.pin_function_select)
			3'h0, 3'h2: begin
				ana_ch = 5'h1f;
			end
			3'h1, 3'h3: begin
				ana_ch = 5'h17;
				ext_ref = 1'b1;
			end
			// RULE9 reduced analog sets
			3'h4: begin
				ana_ch = 5'h0b;
			end
			3'h5: begin
				ana_ch = 5'h03;
				ext_ref = 1'b1;
			end
			3'h6, 3'h7: begin
				ana_ch = 5'h00;
			end
		endcase
	end

	// Channel four sits on port pin five, and pin three is analog when it is the reference.
	assign pin_analog = {ana_ch[4], 1'b0, ana_ch[3] | ext_ref, ana_ch[2:0]};

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_port
			// RULE18 analog pins read low
			assign port_rd[gi] = port_pin_level[gi] & ~pin_analog[gi];
		end
	endgenerate

	// ==========================================
	// Bit clock: dividers stop in sleep, the RC source does not.
	always_comb begin
		// RULE2 clock source select
		unique case (s_ff.conv_clock_select)
			`SACS_CLK_RC: begin
				// RULE15 RC keeps ticking
				half_tick = rc_half_tick;
			end
			default: begin
				half_tick = !sleep && (s_ff.div_cnt == 4'h0);
			end
		endcase
	end

	// RULE11 nineteen half periods
	assign done = (s_ff.state == SACS_CONV) && half_tick && (s_ff.half_cnt == `SACS_HALF_LAST);

	// ==========================================
	// Next state.
	always_comb begin
		logic go_req;
		logic [7:0] cc_rd;
		go_req = 1'b0;
		cc_rd = 8'h00;
		nxt_s = s_ff;
		nxt_result = result_ff;
		nxt_s.rdata = 8'h00;

		// Divider for the core clock sources.
		if ((s_ff.state == SACS_CONV) && (s_ff.conv_clock_select != `SACS_CLK_RC) && !sleep) begin
			if (s_ff.div_cnt == 4'h0) begin
				unique case (s_ff.conv_clock_select)
					`SACS_CLK_DIV8: nxt_s.div_cnt = `SACS_HALF_DIV8;
					`SACS_CLK_DIV32: nxt_s.div_cnt = `SACS_HALF_DIV32;
					default: nxt_s.div_cnt = `SACS_HALF_DIV2;
				endcase
			end else begin
				nxt_s.div_cnt = s_ff.div_cnt - 4'h1;
			end
		end

		// RULE22 half period sequencing
		if ((s_ff.state == SACS_CONV) && half_tick) begin
			nxt_s.half_cnt = s_ff.half_cnt + 5'h01;
			if (s_ff.half_cnt[0] && (s_ff.half_cnt <= `SACS_HALF_RESOLVE_END)) begin
				// RULE20 successive approximation step
				nxt_s.sar = (cmp_above ? s_ff.sar : (s_ff.sar & ~s_ff.trial)) | (s_ff.trial >> 1);
				nxt_s.trial = s_ff.trial >> 1;
			end
		end

		// RULE5 completion effects
		if (done) begin
			nxt_s.state = SACS_IDLE;
			nxt_result = s_ff.sar;
		end

		cc_rd = {s_ff.conv_clock_select, s_ff.input_channel_select,
			s_ff.state == SACS_CONV, 1'b0, s_ff.converter_on};

		if (bus_req.rd) begin
			// RULE7 unimplemented bits zero
			unique case (bus_req.addr)
				`SACS_ADDR_CTRL: nxt_s.rdata = cc_rd;
				`SACS_ADDR_PCFG: nxt_s.rdata = {5'h00, s_ff.pin_function_select};
				`SACS_ADDR_RESULT: nxt_s.rdata = result_ff;
				`SACS_ADDR_PORT_DATA: nxt_s.rdata = {2'h0, port_rd};
				`SACS_ADDR_FLAG: nxt_s.rdata = {1'b0, s_ff.conversion_complete_flag, 6'h00};
				`SACS_ADDR_IRQ_EN: nxt_s.rdata = {1'b0, s_ff.conversion_complete_irq_enable, 6'h00};
				default: nxt_s.rdata = 8'h00;
			endcase
		end

		if (bus_req.wr) begin
			unique case (bus_req.addr)
				`SACS_ADDR_CTRL: begin
					nxt_s.conv_clock_select = bus_req.wdata[`SACS_CTRL_CLK_LSB +: 2];
					nxt_s.input_channel_select = bus_req.wdata[`SACS_CTRL_CHS_LSB +: 3];
					nxt_s.converter_on = bus_req.wdata[`SACS_CTRL_ON_BIT];
					// RULE4 start needs module already on
					// RULE21 ignored while off
					go_req = bus_req.wdata[`SACS_CTRL_GO_BIT] && s_ff.converter_on;
					if (!bus_req.wdata[`SACS_CTRL_GO_BIT] && !done) begin
						nxt_s.state = SACS_IDLE;
					end
				end
				`SACS_ADDR_PCFG: begin
					nxt_s.pin_function_select = bus_req.wdata[2:0];
				end
				`SACS_ADDR_FLAG: begin
					nxt_s.conversion_complete_flag = bus_req.wdata[`SACS_FLAG_BIT];
				end
				`SACS_ADDR_IRQ_EN: begin
					nxt_s.conversion_complete_irq_enable = bus_req.wdata[`SACS_FLAG_BIT];
				end
				default: begin
				end
			endcase
		end

		// A start write arriving while idle launches a fresh conversion.
		if (go_req && (s_ff.state == SACS_IDLE || done)) begin
			nxt_s.state = SACS_CONV;
			nxt_s.half_cnt = 5'h00;
			nxt_s.div_cnt = 4'h0;
			nxt_s.sar = 8'h80;
			nxt_s.trial = 8'h80;
		end else if (go_req) begin
			nxt_s.state = s_ff.state;
		end

		// Hardware set beats a software clear in the same cycle.
		if (done) begin
			nxt_s.conversion_complete_flag = 1'b1;
		end

		// RULE6 module off aborts everything
		if (!nxt_s.converter_on) begin
			nxt_s.state = SACS_IDLE;
		end
	end

	// ==========================================
	// Registers.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// RULE1 reset aborts and powers down
			s_ff <= '0;
			s_ff.state <= SACS_IDLE;
			s_ff.pin_function_select <= `SACS_PCFG_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// RULE10 result keeps value through reset
	always_ff @(posedge clk_sys) begin
		result_ff <= nxt_result;
	end

	// ==========================================
	// Outputs.
	assign bus_rdata = s_ff.rdata;
	assign module_enable = s_ff.converter_on;
	// RULE15 RC runs whenever selected and on
	assign rc_osc_enable = s_ff.converter_on && (s_ff.conv_clock_select == `SACS_CLK_RC);
	// RULE17 hold during conversion
	assign sample_connect = s_ff.converter_on && (s_ff.state == SACS_IDLE);
	// RULE3 channel routing
	assign mux_channel = s_ff.input_channel_select;
	assign dac_code = s_ff.sar;
	assign ext_ref_select = ext_ref;
	assign analog_channel_mask = ana_ch;
	assign conversion_result = result_ff;
	assign conversion_complete_flag = s_ff.conversion_complete_flag;
	assign conversion_complete_irq_enable = s_ff.conversion_complete_irq_enable;

	// ==========================================
	// Checks.
	logic [7:0] len_ff;
	logic slept_ff;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			len_ff <= 8'h00;
			slept_ff <= 1'b0;
		end else if (s_ff.state == SACS_IDLE) begin
			len_ff <= 8'h00;
			slept_ff <= 1'b0;
		end else begin
			len_ff <= len_ff + 8'h01;
			slept_ff <= slept_ff | sleep;
		end
	end

	sequence s_ctrl_read;
		bus_req.rd && (bus_req.addr == `SACS_ADDR_CTRL);
	endsequence

	sequence s_start_write;
		bus_req.wr && (bus_req.addr == `SACS_ADDR_CTRL) && bus_req.wdata[`SACS_CTRL_GO_BIT]
			&& bus_req.wdata[`SACS_CTRL_ON_BIT] && (s_ff.state == SACS_IDLE);
	endsequence

	a_off_aborts: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
		!s_ff.converter_on |-> (s_ff.state == SACS_IDLE) && !module_enable)
		else $error("converter off but still active");

	a_busy_reads_one: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
		s_ctrl_read |=> bus_rdata[`SACS_CTRL_GO_BIT] == ($past(s_ff.state) == SACS_CONV))
		else $error("status bit does not match busy state");

	a_start_when_on: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
		s_start_write ##0 s_ff.converter_on |=> (s_ff.state == SACS_CONV) && !sample_connect)
		else $error("start write did not launch conversion");

	a_start_when_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE21
		s_start_write ##0 !s_ff.converter_on |=> s_ff.state == SACS_IDLE)
		else $error("conversion started while converter off");

	a_done_effects: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
		done |=> conversion_complete_flag && (s_ff.state == SACS_IDLE)
			&& (conversion_result == $past(s_ff.sar)))
		else $error("completion effects missing");

	a_conv_length: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE11
		done && (s_ff.conv_clock_select == `SACS_CLK_DIV2) && !slept_ff && !sleep
			|-> len_ff == (`SACS_HALF_TOTAL - 8'h01))
		else $error("conversion length wrong at core clock over two");

	a_unimpl_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
		s_ctrl_read |=> bus_rdata[1] == 1'b0)
		else $error("unimplemented control bit reads one");

	a_hold_open: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE17
		(s_ff.state == SACS_CONV) |-> !sample_connect)
		else $error("sample switch closed during conversion");

	a_analog_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE18
		bus_req.rd && (bus_req.addr == `SACS_ADDR_PORT_DATA)
			|=> (bus_rdata[5:0] & $past(pin_analog)) == 6'h00)
		else $error("analog pin read as one");

	a_rc_in_sleep: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE15
		sleep && (s_ff.state == SACS_CONV) && (s_ff.conv_clock_select == `SACS_CLK_RC)
			|-> rc_osc_enable)
		else $error("RC clock stopped during sleep conversion");

	a_first_trial: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE22
		s_start_write ##0 s_ff.converter_on |=> dac_code == 8'h80)
		else $error("conversion did not begin with the top bit trial");

	a_tail_stable: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE22
		(s_ff.state == SACS_CONV) && half_tick && (s_ff.half_cnt > `SACS_HALF_RESOLVE_END)
			|=> $stable(dac_code))
		else $error("trial word changed after the last bit was resolved");

	a_div8_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
		(s_ff.state == SACS_CONV) && half_tick && !sleep
			&& (s_ff.conv_clock_select == `SACS_CLK_DIV8)
			|=> (!half_tick)[*3] ##1 (half_tick || sleep || (s_ff.state == SACS_IDLE)))
		else $error("half period at core clock over eight is not four cycles");

endmodule
`default_nettype wire

// ### pkg/sacs_consts.svh
`ifndef SACS_CONSTS_SVH
`define SACS_CONSTS_SVH

// ==========================================
// Register addresses.
`define SACS_ADDR_PORT_DATA 8'h05
`define SACS_ADDR_FLAG 8'h0c
`define SACS_ADDR_IRQ_EN 8'h8c
`define SACS_ADDR_RESULT 8'h1e
`define SACS_ADDR_CTRL 8'h1f
`define SACS_ADDR_PCFG 8'h9f

// ==========================================
// Field positions.
`define SACS_CTRL_ON_BIT 0
`define SACS_CTRL_GO_BIT 2
`define SACS_CTRL_CHS_LSB 3
`define SACS_CTRL_CLK_LSB 6
`define SACS_FLAG_BIT 6

// ==========================================
// Reset values.
`define SACS_CTRL_RESET 8'h00
`define SACS_PCFG_RESET 3'h0

// ==========================================
// Clock select codes, divider reloads in core cycles, and conversion counts in half periods of the bit clock.
`define SACS_CLK_DIV2 2'h0
`define SACS_CLK_DIV8 2'h1
`define SACS_CLK_DIV32 2'h2
`define SACS_CLK_RC 2'h3
`define SACS_HALF_DIV2 4'h0
`define SACS_HALF_DIV8 4'h3
`define SACS_HALF_DIV32 4'hf
`define SACS_HALF_LAST 5'h12
`define SACS_HALF_RESOLVE_END 5'h0f
`define SACS_HALF_TOTAL 8'h13

`endif

// ### pkg/sacs_pkg.sv
`default_nettype none
package sacs_pkg;

	typedef enum logic [0:0] {
		SACS_IDLE,
		SACS_CONV
	} sacs_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sacs_bus_req_t;

	typedef struct packed {
		logic [1:0] conv_clock_select;
		logic [2:0] input_channel_select;
		logic converter_on;
		logic [2:0] pin_function_select;
		logic conversion_complete_flag;
		logic conversion_complete_irq_enable;
		sacs_state_t state;
		logic [3:0] div_cnt;
		logic [4:0] half_cnt;
		logic [7:0] sar;
		logic [7:0] trial;
		logic [7:0] rdata;
	} sacs_state_reg_t;

endpackage
`default_nettype wire

// ### verification/sacs_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module sacs_analog_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [39:0] levels,
	input wire logic [2:0] mux_channel,
	input wire logic [7:0] dac_code,
	input wire logic sample_connect,
	input wire logic rc_osc_enable,
	output logic cmp_above,
	output logic rc_half_tick
);
	logic [7:0] held_ff;
	logic [2:0] rc_cnt_ff;
	// ==========================================
	// Sample and hold.
	// The capacitor tracks the pin while connected and freezes on release.
	always_ff @(posedge clk_sys) begin
		if (sample_connect) begin
			held_ff <= levels[{mux_channel, 3'b000} +: 8];
		end
	end
	assign cmp_above = (held_ff >= dac_code);
	// ==========================================
	// Internal RC oscillator, one half period every five core cycles.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rc_cnt_ff <= 3'h0;
		end else if (rc_osc_enable) begin
			rc_cnt_ff <= (rc_cnt_ff == 3'h4) ? 3'h0 : rc_cnt_ff + 3'h1;
		end else begin
			rc_cnt_ff <= 3'h0;
		end
	end
	assign rc_half_tick = rc_osc_enable && (rc_cnt_ff == 3'h4);
endmodule
`default_nettype wire

// ### verification/sacs_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sacs_consts.svh"
module sacs_top_test
	import sacs_pkg::*;
;
	logic clk_sys, rst_n, sleep, rc_half_tick, cmp_above;
	sacs_bus_req_t bus_req;
	logic [7:0] bus_rdata, dac_code, conversion_result;
	logic [5:0] port_pin_level;
	logic module_enable, rc_osc_enable, sample_connect, ext_ref_select;
	logic conversion_complete_flag, conversion_complete_irq_enable;
	logic [2:0] mux_channel;
	logic [4:0] analog_channel_mask;
	logic [39:0] levels = 40'h7f80ff005a;
	logic [5:0] pcfg_tab [8] = '{6'h1f, 6'h37, 6'h1f, 6'h37, 6'h0b, 6'h23, 6'h00, 6'h00};
	int err_total, n_tests, cyc, i;
	sacs_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.sleep(sleep), .rc_half_tick(rc_half_tick), .cmp_above(cmp_above),
		.port_pin_level(port_pin_level), .module_enable(module_enable),
		.rc_osc_enable(rc_osc_enable), .sample_connect(sample_connect),
		.mux_channel(mux_channel), .dac_code(dac_code), .ext_ref_select(ext_ref_select),
		.analog_channel_mask(analog_channel_mask), .conversion_result(conversion_result),
		.conversion_complete_flag(conversion_complete_flag),
		.conversion_complete_irq_enable(conversion_complete_irq_enable));
	sacs_analog_model partner (.clk_sys(clk_sys), .rst_n(rst_n), .levels(levels),
		.mux_channel(mux_channel), .dac_code(dac_code), .sample_connect(sample_connect),
		.rc_osc_enable(rc_osc_enable), .cmp_above(cmp_above), .rc_half_tick(rc_half_tick));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
	end
	// ==========================================
	// Checking and bus tasks.
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_range(input string what, input int lo, input int hi, input int got);
		n_tests++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
		#1;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1;
		chk(what, exp, bus_rdata);
	endtask
	task automatic convert(input logic [1:0] cs, input logic [2:0] ch, input int lo, input int hi);
		logic [7:0] c;
		int t0, k;
		c = {cs, ch, 3'b001};
		wr(`SACS_ADDR_CTRL, c);
		// Let the capacitor settle on the new channel before starting.
		// acquisition wait
		repeat (64) @(posedge clk_sys);
		wr(`SACS_ADDR_CTRL, c | 8'h04);
		#1;
		t0 = cyc;
		chk("sample_connect", 8'h00, {7'h0, sample_connect});
		chk("mux_channel", {5'h0, ch}, {5'h0, mux_channel});
		rchk("busy", `SACS_ADDR_CTRL, c | 8'h04);
		for (k = 0; k < 400 && conversion_complete_flag !== 1'b1; k++) begin
			@(posedge clk_sys);
			#1;
		end
		if (k == 400) begin
			err_total++;
			$display("ERROR conversion_complete_flag expected 1 seen %b", conversion_complete_flag);
			close_out();
		end
		chk_range("cycles", lo, hi, cyc - t0);
		chk("result", levels[{ch, 3'b000} +: 8], conversion_result);
		rchk("result reg", `SACS_ADDR_RESULT, levels[{ch, 3'b000} +: 8]);
		rchk("done", `SACS_ADDR_CTRL, c);
		rchk("flag", `SACS_ADDR_FLAG, 8'h40);
		chk("sample_connect", 8'h01, {7'h0, sample_connect});
		wr(`SACS_ADDR_FLAG, 8'h00);
	endtask
	// ==========================================
	// Main sequence.
	initial begin
		rst_n = 1'b0;
		bus_req = '0;
		sleep = 1'b0;
		port_pin_level = 6'h3f;
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		rchk("ctrl", `SACS_ADDR_CTRL, `SACS_CTRL_RESET);
		rchk("pcfg", `SACS_ADDR_PCFG, 8'h00);
		rchk("unmapped", 8'h40, 8'h00);
		chk("module_enable", 8'h00, {7'h0, module_enable});
		wr(`SACS_ADDR_CTRL, 8'hc6);
		rchk("ctrl off", `SACS_ADDR_CTRL, 8'hc0);
		chk("rc_osc_enable", 8'h00, {7'h0, rc_osc_enable});
		for (i = 0; i < 8; i++) begin
			wr(`SACS_ADDR_PCFG, {5'h1f, i[2:0]});
			rchk("pcfg", `SACS_ADDR_PCFG, {5'h0, i[2:0]});
			chk("mask", {3'h0, pcfg_tab[i][4:0]}, {3'h0, analog_channel_mask});
			chk("ext_ref", {7'h0, pcfg_tab[i][5]}, {7'h0, ext_ref_select});
			rchk("port", `SACS_ADDR_PORT_DATA, {2'h0, ~pcfg_tab[i][4], 1'b1,
				~(pcfg_tab[i][3] | pcfg_tab[i][5]), ~pcfg_tab[i][2:0]});
		end
		wr(`SACS_ADDR_PCFG, 8'h00);
		wr(`SACS_ADDR_CTRL, 8'h01);
		chk("module_enable", 8'h01, {7'h0, module_enable});
		for (i = 0; i < 5; i++) begin
			convert(2'h0, i[2:0], 19, 19);
		end
		convert(2'h1, 3'h3, 73, 77);
		@(posedge clk_sys);
		sleep <= 1'b1;
		convert(2'h3, 3'h1, 90, 100);
		chk("rc_osc_enable", 8'h01, {7'h0, rc_osc_enable});
		@(posedge clk_sys);
		sleep <= 1'b0;
		convert(2'h2, 3'h2, 289, 305);
		wr(`SACS_ADDR_CTRL, 8'h00);
		wr(`SACS_ADDR_CTRL, 8'h05);
		rchk("on and go", `SACS_ADDR_CTRL, 8'h01);
		wr(`SACS_ADDR_IRQ_EN, 8'h40);
		rchk("irq_en", `SACS_ADDR_IRQ_EN, 8'h40);
		chk("irq_en out", 8'h01, {7'h0, conversion_complete_irq_enable});
		wr(`SACS_ADDR_CTRL, 8'h89);
		wr(`SACS_ADDR_CTRL, 8'h8d);
		chk("sample_connect", 8'h00, {7'h0, sample_connect});
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("module_enable", 8'h00, {7'h0, module_enable});
		@(posedge clk_sys);
		rst_n <= 1'b1;
		rchk("ctrl", `SACS_ADDR_CTRL, 8'h00);
		rchk("irq_en", `SACS_ADDR_IRQ_EN, 8'h00);
		repeat (320) @(posedge clk_sys);
		rchk("flag", `SACS_ADDR_FLAG, 8'h00);
		rchk("kept result", `SACS_ADDR_RESULT, 8'hff);
		close_out();
	end
endmodule
`default_nettype wire
